// ---- design/tma_pkg.sv ----
// Shared constants, types and helper functions of the temperature monitor alarm block.
// Assumes one 10 MHz clock domain; registers are reached over a simple strobe port.
package tma_pkg;

  // Sizes.
  localparam int TMA_MON     = 3;
  localparam int TMA_PORTS   = 12;
  localparam int TMA_DW      = 12;
  localparam int TMA_ACC_W   = 17;
  localparam int TMA_CNT_W   = 6;
  localparam int TMA_REG_W   = 16;
  localparam int TMA_ADDR_W  = 8;
  localparam int TMA_ASSOC_W = 5;
  localparam int TMA_SEL_W   = 2;

  // Register addresses.
  localparam logic [7:0] TMA_ADDR_CTRL      = 8'h00;
  localparam logic [7:0] TMA_ADDR_AVG       = 8'h01;
  localparam logic [7:0] TMA_ADDR_THR_BASE  = 8'h02;
  localparam logic [7:0] TMA_ADDR_FLAG_BASE = 8'h08;
  localparam logic [7:0] TMA_ADDR_PORT_BASE = 8'h10;

  // Field positions.
  localparam int TMA_CTRL_OVH_BIT  = 7;
  localparam int TMA_CTRL_MON_LSB  = 8;
  localparam int TMA_FLAG_HIGH_BIT = 2;
  localparam int TMA_FLAG_LOW_BIT  = 1;

  // Reset values.
  localparam logic [11:0] TMA_THR_HI_RST  = 12'h7FF;
  localparam logic [11:0] TMA_THR_LO_RST  = 12'h800;
  localparam logic [11:0] TMA_PORT_RST    = 12'h000;
  localparam logic [5:0]  TMA_AVG_RST     = 6'h00;
  localparam logic [2:0]  TMA_MON_EN_RST  = 3'h0;

  // Partner port codes: data-register address of the partner.
  localparam logic [4:0] TMA_ASSOC_P0 = 5'h02;
  localparam logic [4:0] TMA_ASSOC_P1 = 5'h03;

  // Overheat trip point in result counts of 0.125 degC.
  localparam int          TMA_OVH_DEGC      = 145;
  localparam int          TMA_LSB_MILLIDEG  = 125;
  localparam logic [11:0] TMA_OVH_COUNT     = 12'(TMA_OVH_DEGC * 1000 / TMA_LSB_MILLIDEG);

  typedef struct packed {
    logic                               ovh_en;
    logic [TMA_MON-1:0]                 mon_en;
    logic [5:0]                         avg_cfg;
    logic [TMA_MON-1:0][TMA_DW-1:0]     hi;
    logic [TMA_MON-1:0][TMA_DW-1:0]     lo;
    logic [TMA_PORTS-1:0][TMA_DW-1:0]   port_cfg;
    logic [TMA_REG_W-1:0]               rdata;
    logic                               rvalid;
    logic                               ovh_pulse;
  } tma_main_type;

  localparam tma_main_type TMA_MAIN_RST = '{
    ovh_en:    1'b0,
    mon_en:    TMA_MON_EN_RST,
    avg_cfg:   TMA_AVG_RST,
    hi:        {TMA_MON{TMA_THR_HI_RST}},
    lo:        {TMA_MON{TMA_THR_LO_RST}},
    port_cfg:  {TMA_PORTS{TMA_PORT_RST}},
    rdata:     16'h0000,
    rvalid:    1'b0,
    ovh_pulse: 1'b0
  };

  typedef struct packed {
    logic [TMA_CNT_W-1:0]        cnt;
    logic signed [TMA_ACC_W-1:0] acc;
    logic [TMA_DW-1:0]           result;
    logic                        valid;
  } tma_avg_type;

  typedef struct packed {
    logic high;
    logic low;
  } tma_alarm_type;

  // Samples per averaged result: 4, 8, 16 or 32.
  function automatic logic [TMA_CNT_W-1:0] tma_avg_samples(input logic [1:0] sel);
    tma_avg_samples = 6'h04 << sel;
  endfunction

  function automatic logic [2:0] tma_avg_shift(input logic [1:0] sel);
    tma_avg_shift = {1'b0, sel} + 3'h2;
  endfunction

  function automatic logic tma_is_port(input logic [7:0] addr);
    tma_is_port = (addr >= TMA_ADDR_PORT_BASE) &&
                  (addr < TMA_ADDR_PORT_BASE + 8'(TMA_PORTS));
  endfunction

endpackage

// ---- design/tma_avg.sv ----
// Sample averager for one temperature monitor.
// Assumes raw samples arrive as one-cycle strobes on the same clock.
`timescale 1ns/100ps
module tma_avg
  import tma_pkg::*;
#(
  parameter int DATA_W = TMA_DW
) (
  // Clock and reset.
  input  wire logic              i_mclk,
  input  wire logic              i_reset_n,
  // Control.
  input  wire logic              i_clear,
  input  wire logic              i_enable,
  input  wire logic [1:0]        i_sel,
  // Raw samples.
  input  wire logic              i_sample_valid,
  input  wire logic [DATA_W-1:0] i_sample,
  // Averaged result.
  output logic      [DATA_W-1:0] o_result,
  output logic                   o_valid
);

  if (DATA_W != TMA_DW) begin : g_chk
    $error("tma_avg supports only the 12-bit sample width");
  end

  tma_avg_type q;
  tma_avg_type d;

  always_comb begin
    logic signed [TMA_ACC_W-1:0] sum;
    logic signed [TMA_ACC_W-1:0] mean;
    sum = q.acc + {{(TMA_ACC_W-TMA_DW){i_sample[DATA_W-1]}}, i_sample};
    mean = sum >>> tma_avg_shift(i_sel);
    d = q;
    d.valid = 1'b0;
    // A disabled monitor drops any partial sum so the next run starts clean.
    if (i_clear || !i_enable) begin
      d.cnt = '0;
      d.acc = '0;
    end else if (i_sample_valid) begin
      if ((q.cnt + 6'h01) >= tma_avg_samples(i_sel)) begin
        d.result = mean[TMA_DW-1:0];
        d.valid  = 1'b1;
        d.cnt    = '0;
        d.acc    = '0;
      end else begin
        d.cnt = q.cnt + 6'h01;
        d.acc = sum;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_result = q.result;
  assign o_valid  = q.valid;

endmodule // tma_avg

// ---- design/tma_alarm.sv ----
// High and low alarm flags of one temperature monitor.
// Assumes results and thresholds are signed counts of 0.125 degC on the same clock.
`timescale 1ns/100ps
module tma_alarm
  import tma_pkg::*;
(
  // Clock and reset.
  input  wire logic              i_mclk,
  input  wire logic              i_reset_n,
  // Control.
  input  wire logic              i_clear_all,
  input  wire logic              i_enable,
  input  wire logic              i_flag_clear,
  // Result and limits.
  input  wire logic              i_result_valid,
  input  wire logic [TMA_DW-1:0] i_result,
  input  wire logic [TMA_DW-1:0] i_high_limit,
  input  wire logic [TMA_DW-1:0] i_low_limit,
  // Flags.
  output logic                   o_high_flag,
  output logic                   o_low_flag
);

  tma_alarm_type q;
  tma_alarm_type d;
  logic          set_high;
  logic          set_low;

  // Only a fresh result may raise a flag, so a cleared flag stays clear until then.
  assign set_high = i_result_valid && i_enable &&
                    ($signed(i_result) > $signed(i_high_limit));
  assign set_low  = i_result_valid && i_enable &&
                    ($signed(i_result) < $signed(i_low_limit));

  always_comb begin
    d = q;
    if (i_clear_all) begin
      d = '0;
    end else begin
      // A set in the cycle of the clearing read wins, so no event is lost.
      d.high = (q.high && !i_flag_clear) || set_high;
      d.low  = (q.low && !i_flag_clear) || set_low;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_high_flag = q.high;
  assign o_low_flag  = q.low;

  property p_high_set;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (i_result_valid && i_enable && !i_clear_all &&
       $signed(i_result) > $signed(i_high_limit)) |=> o_high_flag;
  endproperty
  a_high_set: assert property (p_high_set) else $error("high flag not raised");

  property p_low_set;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (i_result_valid && i_enable && !i_clear_all &&
       $signed(i_result) < $signed(i_low_limit)) |=> o_low_flag;
  endproperty
  a_low_set: assert property (p_low_set) else $error("low flag not raised");

  property p_flag_hold;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (o_high_flag && !i_flag_clear && !i_clear_all) |=> o_high_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("high flag dropped early");

  property p_no_raise;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (!o_low_flag ##1 o_low_flag) |-> ($past(i_result_valid) && $past(i_enable));
  endproperty
  a_no_raise: assert property (p_no_raise) else $error("low flag rose without a result");

  property p_disabled_quiet;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (!i_enable && !o_high_flag) |=> !o_high_flag;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled monitor alarmed");

endmodule // tma_alarm

// ---- design/tma_top.sv ----
// Temperature monitor configuration, averaging and alarm comparison for three monitors.
// Assumes samples and register strobes come from logic on the same 10 MHz clock.
`timescale 1ns/100ps
module tma_top
  import tma_pkg::*;
(
  // Clock and reset.
  input  wire logic                                    i_mclk,
  input  wire logic                                    i_reset_n,
  // Register access.
  input  wire logic                                    i_reg_wr,
  input  wire logic                                    i_reg_rd,
  input  wire logic [TMA_ADDR_W-1:0]                   i_reg_addr,
  input  wire logic [TMA_REG_W-1:0]                    i_reg_wdata,
  output logic      [TMA_REG_W-1:0]                    o_reg_rdata,
  output logic                                         o_reg_rvalid,
  // Raw temperature samples: index 0 internal, 1 and 2 remote.
  input  wire logic [TMA_MON-1:0]                      i_sample_valid,
  input  wire logic [TMA_MON-1:0][TMA_DW-1:0]          i_sample,
  // Averaged results.
  output logic      [TMA_MON-1:0][TMA_DW-1:0]          o_temp_result,
  output logic      [TMA_MON-1:0]                      o_temp_valid,
  // Alarm flags.
  output logic      [TMA_MON-1:0]                      o_high_flag,
  output logic      [TMA_MON-1:0]                      o_low_flag,
  // Monitor control and overheat reset.
  output logic      [TMA_MON-1:0]                      o_monitor_enable,
  output logic                                         o_overheat_reset,
  // Partner port fields.
  output logic      [TMA_PORTS-1:0][TMA_ASSOC_W-1:0]   o_port_assoc
);

  tma_main_type               q;
  tma_main_type               d;
  logic [TMA_MON-1:0]         flag_clear;
  logic                       ovh_trip;
  logic [TMA_ADDR_W-1:0]      port_off;
  logic [3:0]                 port_idx;

  assign port_off = i_reg_addr - TMA_ADDR_PORT_BASE;
  assign port_idx = port_off[3:0];

  // Reading a flag register clears it in the same cycle as the flags are captured.
  always_comb begin
    for (int i = 0; i < TMA_MON; i++) begin
      flag_clear[i] = i_reg_rd && (i_reg_addr == TMA_ADDR_FLAG_BASE + 8'(i));
    end
  end

  // Thermal shutdown looks at each fresh internal result while that monitor runs.
  assign ovh_trip = q.ovh_en && q.mon_en[0] && o_temp_valid[0] &&
                    ($signed(o_temp_result[0]) > $signed(TMA_OVH_COUNT));

  for (genvar m = 0; m < TMA_MON; m++) begin : g_mon
    tma_avg #(
      .DATA_W         (TMA_DW)
    ) u_avg (
      .i_mclk         (i_mclk),
      .i_reset_n      (i_reset_n),
      .i_clear        (q.ovh_pulse),
      .i_enable       (q.mon_en[m]),
      .i_sel          (q.avg_cfg[TMA_SEL_W*m +: TMA_SEL_W]),
      .i_sample_valid (i_sample_valid[m]),
      .i_sample       (i_sample[m]),
      .o_result       (o_temp_result[m]),
      .o_valid        (o_temp_valid[m])
    );

    tma_alarm u_alarm (
      .i_mclk         (i_mclk),
      .i_reset_n      (i_reset_n),
      .i_clear_all    (q.ovh_pulse),
      .i_enable       (q.mon_en[m]),
      .i_flag_clear   (flag_clear[m]),
      .i_result_valid (o_temp_valid[m]),
      .i_result       (o_temp_result[m]),
      .i_high_limit   (q.hi[m]),
      .i_low_limit    (q.lo[m]),
      .o_high_flag    (o_high_flag[m]),
      .o_low_flag     (o_low_flag[m])
    );
  end

  // Register writes, readback and the overheat reset.
  always_comb begin
    logic [TMA_REG_W-1:0] rd;
    rd = 16'h0000;
    d = q;
    d.rvalid    = i_reg_rd;
    d.ovh_pulse = 1'b0;

    if (i_reg_wr) begin
      if (i_reg_addr == TMA_ADDR_CTRL) begin
        d.ovh_en = i_reg_wdata[TMA_CTRL_OVH_BIT];
        d.mon_en = i_reg_wdata[TMA_CTRL_MON_LSB +: TMA_MON];
      end
      if (i_reg_addr == TMA_ADDR_AVG) begin
        d.avg_cfg = i_reg_wdata[5:0];
      end
      for (int i = 0; i < TMA_MON; i++) begin
        if (i_reg_addr == TMA_ADDR_THR_BASE + 8'(2 * i)) begin
          d.hi[i] = i_reg_wdata[TMA_DW-1:0];
        end
        if (i_reg_addr == TMA_ADDR_THR_BASE + 8'(2 * i + 1)) begin
          d.lo[i] = i_reg_wdata[TMA_DW-1:0];
        end
      end
      if (tma_is_port(i_reg_addr)) begin
        // The whole 12-bit field is kept; only bits 4:0 leave as the partner code.
        d.port_cfg[port_idx] = i_reg_wdata[TMA_DW-1:0];
      end
    end

    if (i_reg_rd) begin
      if (i_reg_addr == TMA_ADDR_CTRL) begin
        rd[TMA_CTRL_OVH_BIT] = q.ovh_en;
        rd[TMA_CTRL_MON_LSB +: TMA_MON] = q.mon_en;
      end
      if (i_reg_addr == TMA_ADDR_AVG) begin
        rd[5:0] = q.avg_cfg;
      end
      for (int i = 0; i < TMA_MON; i++) begin
        if (i_reg_addr == TMA_ADDR_THR_BASE + 8'(2 * i)) begin
          rd[TMA_DW-1:0] = q.hi[i];
        end
        if (i_reg_addr == TMA_ADDR_THR_BASE + 8'(2 * i + 1)) begin
          rd[TMA_DW-1:0] = q.lo[i];
        end
        if (flag_clear[i]) begin
          rd[TMA_FLAG_HIGH_BIT] = o_high_flag[i];
          rd[TMA_FLAG_LOW_BIT]  = o_low_flag[i];
        end
      end
      if (tma_is_port(i_reg_addr)) begin
        rd[TMA_DW-1:0] = q.port_cfg[port_idx];
      end
      d.rdata = rd;
    end

    // The trip wins over a write in the same cycle: the device returns to defaults.
    if (ovh_trip) begin
      d = TMA_MAIN_RST;
      d.ovh_pulse = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= TMA_MAIN_RST;
    end else begin
      q <= d;
    end
  end

  assign o_reg_rdata      = q.rdata;
  assign o_reg_rvalid     = q.rvalid;
  assign o_monitor_enable = q.mon_en;
  assign o_overheat_reset = q.ovh_pulse;

  always_comb begin
    for (int p = 0; p < TMA_PORTS; p++) begin
      o_port_assoc[p] = q.port_cfg[p][TMA_ASSOC_W-1:0];
    end
  end

  // Helper logic for the checks below: samples seen since the last averaged result.
  logic [TMA_MON-1:0][TMA_CNT_W-1:0] seen_q;
  logic [TMA_MON-1:0][TMA_CNT_W-1:0] seen_d;
  logic [3:0]                        last_port_q;
  logic [TMA_ASSOC_W-1:0]            last_code_q;

  always_comb begin
    for (int i = 0; i < TMA_MON; i++) begin
      seen_d[i] = seen_q[i];
      if (q.ovh_pulse || !q.mon_en[i]) begin
        seen_d[i] = '0;
      end else if (o_temp_valid[i]) begin
        seen_d[i] = {5'h00, i_sample_valid[i]};
      end else if (i_sample_valid[i]) begin
        seen_d[i] = seen_q[i] + 6'h01;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seen_q      <= '0;
      last_port_q <= 4'h0;
      last_code_q <= 5'h00;
    end else begin
      seen_q <= seen_d;
      if (i_reg_wr && tma_is_port(i_reg_addr)) begin
        last_port_q <= port_idx;
        last_code_q <= i_reg_wdata[TMA_ASSOC_W-1:0];
      end
    end
  end

  property p_avg_int;
    @(posedge i_mclk) disable iff (!i_reset_n)
      o_temp_valid[0] |-> (seen_q[0] == tma_avg_samples(q.avg_cfg[1:0]));
  endproperty
  a_avg_int: assert property (p_avg_int) else $error("internal sample count wrong");

  property p_avg_r1;
    @(posedge i_mclk) disable iff (!i_reset_n)
      o_temp_valid[1] |-> (seen_q[1] == tma_avg_samples(q.avg_cfg[3:2]));
  endproperty
  a_avg_r1: assert property (p_avg_r1) else $error("remote 1 sample count wrong");

  property p_avg_r2;
    @(posedge i_mclk) disable iff (!i_reset_n)
      o_temp_valid[2] |-> (seen_q[2] == tma_avg_samples(q.avg_cfg[5:4]));
  endproperty
  a_avg_r2: assert property (p_avg_r2) else $error("remote 2 sample count wrong");

  property p_port_write;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (i_reg_wr && tma_is_port(i_reg_addr) && !ovh_trip) |=>
        (o_port_assoc[last_port_q] == last_code_q);
  endproperty
  a_port_write: assert property (p_port_write) else $error("partner code not stored");

  property p_overheat;
    @(posedge i_mclk) disable iff (!i_reset_n)
      ovh_trip |=> (o_overheat_reset && (o_monitor_enable == TMA_MON_EN_RST))
                   ##1 (!o_overheat_reset && (o_high_flag == '0) && (o_low_flag == '0));
  endproperty
  a_overheat: assert property (p_overheat) else $error("overheat reset not applied");

  property p_read_answer;
    @(posedge i_mclk) disable iff (!i_reset_n)
      i_reg_rd |=> o_reg_rvalid ##1 (!o_reg_rvalid || $past(i_reg_rd));
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer timing wrong");

  // The same checks for every monitor; the limit checks skip a trip, which wins.
  for (genvar m = 0; m < TMA_MON; m++) begin : g_chk
    property p_flag_clear;
      @(posedge i_mclk) disable iff (!i_reset_n)
        (flag_clear[m] && !o_temp_valid[m]) |=> (!o_high_flag[m] && !o_low_flag[m]);
    endproperty
    a_flag_clear: assert property (p_flag_clear)
      else $error("flag kept after its read");

    property p_flag_readback;
      @(posedge i_mclk) disable iff (!i_reset_n)
        (flag_clear[m] && !ovh_trip) |=>
          ((o_reg_rdata[TMA_FLAG_HIGH_BIT] == $past(o_high_flag[m])) &&
           (o_reg_rdata[TMA_FLAG_LOW_BIT] == $past(o_low_flag[m])));
    endproperty
    a_flag_readback: assert property (p_flag_readback)
      else $error("flag bits read back wrong");

    property p_idle_no_result;
      @(posedge i_mclk) disable iff (!i_reset_n)
        !q.mon_en[m] |=> !o_temp_valid[m];
    endproperty
    a_idle_no_result: assert property (p_idle_no_result)
      else $error("disabled monitor averaged");

    property p_idle_no_low;
      @(posedge i_mclk) disable iff (!i_reset_n)
        (!q.mon_en[m] && !o_low_flag[m]) |=> !o_low_flag[m];
    endproperty
    a_idle_no_low: assert property (p_idle_no_low)
      else $error("disabled monitor raised low flag");

    property p_high_limit_write;
      @(posedge i_mclk) disable iff (!i_reset_n)
        (i_reg_wr && (i_reg_addr == TMA_ADDR_THR_BASE + 8'(2 * m)) && !ovh_trip) |=>
          (q.hi[m] == $past(i_reg_wdata[TMA_DW-1:0]));
    endproperty
    a_high_limit_write: assert property (p_high_limit_write)
      else $error("high limit not stored");

    property p_low_limit_write;
      @(posedge i_mclk) disable iff (!i_reset_n)
        (i_reg_wr && (i_reg_addr == TMA_ADDR_THR_BASE + 8'(2 * m + 1)) && !ovh_trip) |=>
          (q.lo[m] == $past(i_reg_wdata[TMA_DW-1:0]));
    endproperty
    a_low_limit_write: assert property (p_low_limit_write)
      else $error("low limit not stored");

    // At least four samples lie between two results, so a result never repeats at once.
    property p_single_result;
      @(posedge i_mclk) disable iff (!i_reset_n)
        o_temp_valid[m] |=> !o_temp_valid[m];
    endproperty
    a_single_result: assert property (p_single_result)
      else $error("averaged results back to back");
  end

  property p_trip_needs_enable;
    @(posedge i_mclk) disable iff (!i_reset_n)
      o_overheat_reset |-> ($past(q.ovh_en) && $past(q.mon_en[0]));
  endproperty
  a_trip_needs_enable: assert property (p_trip_needs_enable)
    else $error("overheat reset without its enables");

  property p_trip_point;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (q.ovh_en && q.mon_en[0] && o_temp_valid[0] &&
       ($signed(o_temp_result[0]) > $signed(TMA_OVH_COUNT))) |=> o_overheat_reset;
  endproperty
  a_trip_point: assert property (p_trip_point)
    else $error("hot internal result did not trip");

  property p_trip_defaults;
    @(posedge i_mclk) disable iff (!i_reset_n)
      o_overheat_reset |-> ((o_port_assoc == '0) && (q.avg_cfg == TMA_AVG_RST) &&
                            !q.ovh_en && (q.hi == {TMA_MON{TMA_THR_HI_RST}}));
  endproperty
  a_trip_defaults: assert property (p_trip_defaults)
    else $error("registers not at defaults after trip");

  c_int_high: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_high_flag[0]));
  c_r1_low: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_low_flag[1]));
  c_overheat: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
    ovh_trip);
  c_read_clear: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_low_flag[1] && flag_clear[1] ##1 !o_low_flag[1]);
  c_partner_p1: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
    o_port_assoc[1] == TMA_ASSOC_P1);

endmodule // tma_top

// ---- sim/tma_host_model.sv ----
// Host-side register master for the temperature alarm block.
// Assumes single-cycle strobes launched just after a rising edge of the shared clock.
`timescale 1ns/100ps
module tma_host_model
  import tma_pkg::*;
(
  // Clock.
  input  wire logic                  i_mclk,
  // Register strobes.
  output logic                       o_reg_wr,
  output logic                       o_reg_rd,
  output logic [TMA_ADDR_W-1:0]      o_reg_addr,
  output logic [TMA_REG_W-1:0]       o_reg_wdata
);
  initial begin
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_addr  = 8'h00;
    o_reg_wdata = 16'h0000;
  end

  // Limits leave as signed 0.125 degC counts, partner codes as raw addresses.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    o_reg_wr    <= 1'b1;
    o_reg_addr  <= a;
    o_reg_wdata <= d;
    @(posedge i_mclk);
    o_reg_wr    <= 1'b0;
    o_reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    o_reg_rd   <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_mclk);
    o_reg_rd   <= 1'b0;
    o_reg_addr <= ~a;
  endtask
endmodule // tma_host_model

// ---- sim/testbench.sv ----
// Self-checking bench for the temperature monitor alarm block.
// Assumes the host model drives registers; samples come from this bench.
`timescale 1ns/100ps
module testbench;
  import tma_pkg::*;
  logic                            i_mclk;
  logic                            i_reset_n;
  logic                            reg_wr, reg_rd;
  logic                            ovh_seen = 1'b0;
  logic [TMA_ADDR_W-1:0]           reg_addr;
  logic [TMA_REG_W-1:0]            reg_wdata, o_reg_rdata, d;
  logic                            o_reg_rvalid, o_overheat_reset;
  logic [TMA_MON-1:0]              i_sample_valid, o_temp_valid, o_high_flag, o_low_flag;
  logic [TMA_MON-1:0]              o_monitor_enable;
  logic [TMA_MON-1:0][TMA_DW-1:0]  i_sample, o_temp_result;
  logic [TMA_PORTS-1:0][4:0]       o_port_assoc;
  logic [15:0]                     exp_q[$];
  int                              vcnt[3];
  int                              failures, n_tests, seed, m, s, p;
  // Per monitor: high limit, low limit, sample base, expected {high, low}.
  logic [11:0] thr_hi[3] = '{12'h0C8, 12'h0C8, 12'hF00};
  logic [11:0] thr_lo[3] = '{12'hFF0, 12'hFF0, 12'hE00};
  logic [11:0] base[3]   = '{12'h0CF, 12'hFDF, 12'hEFF};
  logic [1:0]  flg[3]    = '{2'b10, 2'b01, 2'b00};

  tma_host_model host (.i_mclk(i_mclk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
                       .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));

  tma_top dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_reg_wr(reg_wr),
               .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
               .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
               .i_sample_valid(i_sample_valid), .i_sample(i_sample),
               .o_temp_result(o_temp_result), .o_temp_valid(o_temp_valid),
               .o_high_flag(o_high_flag), .o_low_flag(o_low_flag),
               .o_monitor_enable(o_monitor_enable), .o_overheat_reset(o_overheat_reset),
               .o_port_assoc(o_port_assoc));

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask

  // Alternating v and v+2 averages to v+1 only over the exact sample count.
  task automatic feed(input int mi, input int n, input logic [11:0] v, input logic en);
    int k;
    int v0;
    v0 = vcnt[mi];
    for (k = 0; k < n; k++) begin
      @(posedge i_mclk);
      i_sample_valid[mi] <= 1'b1;
      i_sample[mi]       <= k[0] ? v + 12'h002 : v;
    end
    @(posedge i_mclk);
    i_sample_valid[mi] <= 1'b0;
    for (k = 0; k < 4; k++) @(negedge i_mclk);
    chk(16'(vcnt[mi] - v0), 16'(en));
    if (en) chk(o_temp_result[mi], v + 12'h001);
  endtask

  // A read answer is taken off the oldest note when it appears.
  always @(negedge i_mclk) begin
    for (int i = 0; i < 3; i++) if (o_temp_valid[i] === 1'b1) vcnt[i]++;
    if (o_reg_rvalid === 1'b1) begin
      if (exp_q.size() > 0) chk(o_reg_rdata, exp_q.pop_front());
      else chk(16'h0001, 16'h0000);
    end
  end

  always @(posedge i_mclk) if (o_overheat_reset === 1'b1) ovh_seen <= 1'b1;

  initial begin
    #(100000 * 100);
    failures++;
    final_report();
  end

  initial begin
    seed = 99;
    i_reset_n = 1'b0;
    i_sample_valid = '0;
    i_sample = '0;
    repeat (20) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rd_chk(8'h00, 16'h0000);
    rd_chk(8'h01, 16'h0000);
    for (m = 2; m < 8; m++) rd_chk(8'(m), m[0] ? 16'h0800 : 16'h07FF);
    rd_chk(8'h30, 16'h0000);
    feed(0, 4, 12'h010, 1'b0);
    $display("Test reset values and disabled monitor done");
    host.wr(8'h00, 16'h0700);
    @(negedge i_mclk);
    chk(o_monitor_enable, 3'h7);
    rd_chk(8'h00, 16'h0700);
    for (s = 0; s < 4; s++) begin
      d = 16'({s[1:0], s[1:0], s[1:0]});
      host.wr(8'h01, d);
      rd_chk(8'h01, d);
      for (m = 0; m < 3; m++) feed(m, 4 << s, 12'($random(seed)) & 12'h3FF, 1'b1);
    end
    $display("Test averaging codes done");
    for (m = 0; m < 3; m++) begin
      host.wr(8'(2 + 2 * m), 16'(thr_hi[m]));
      host.wr(8'(3 + 2 * m), 16'(thr_lo[m]));
      feed(m, 32, base[m], 1'b1);
      chk({o_high_flag[m], o_low_flag[m]}, flg[m]);
      rd_chk(8'(8 + m), 16'({flg[m], 1'b0}));
      @(negedge i_mclk);
      chk({o_high_flag[m], o_low_flag[m]}, 2'b00);
    end
    $display("Test signed limits and flags done");
    for (p = 0; p < 12; p++) begin
      d = (p < 2) ? 16'(2 + p) : 16'($random(seed));
      host.wr(8'(16 + p), d);
      rd_chk(8'(16 + p), d & 16'h0FFF);
      chk(o_port_assoc[p], d[4:0]);
    end
    $display("Test partner port fields done");
    host.wr(8'h00, 16'h0780);
    feed(0, 32, 12'h48F, 1'b1);
    chk(ovh_seen, 1'b1);
    chk(o_monitor_enable, 3'h0);
    rd_chk(8'h02, 16'h07FF);
    rd_chk(8'h00, 16'h0000);
    repeat (4) @(negedge i_mclk);
    chk(16'(exp_q.size()), 16'h0000);
    $display("Test overheat reset done");
    final_report();
  end
endmodule // testbench
